// ### src/ecr_pkg.sv
// Constants for the bridge extended configuration register bank.
// Assumes byte addresses on a 32-bit Avalon-MM slave, one word per register.
package ecr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int AUX_W  = 4;

  // Register byte offsets
  localparam logic [11:0] OFS_SEC_ERR_PTR  = 12'h138;
  localparam logic [11:0] OFS_SEC_HDR_0    = 12'h13C;
  localparam logic [11:0] OFS_SEC_HDR_1    = 12'h140;
  localparam logic [11:0] OFS_SEC_HDR_2    = 12'h144;
  localparam logic [11:0] OFS_SEC_HDR_3    = 12'h148;
  localparam logic [11:0] OFS_VC_CAP_HDR   = 12'h150;
  localparam logic [11:0] OFS_PORT_VC_CAP1 = 12'h154;
  localparam logic [11:0] OFS_PORT_VC_CAP2 = 12'h158;
  localparam logic [11:0] OFS_PORT_VC_CTST = 12'h15C;
  localparam logic [11:0] OFS_VC0_RES_CAP  = 12'h160;
  localparam logic [11:0] OFS_VC0_RES_CTRL = 12'h164;
  localparam logic [11:0] OFS_VC0_RES_STAT = 12'h168;
  localparam logic [11:0] OFS_AUX_IO       = 12'h304;
  localparam logic [11:0] OFS_TIMERS       = 12'h310;

  // Error pointer field
  localparam int             PTR_W     = 5;
  localparam logic [4:0]     PTR_RESET = 5'h00;

  // Captured header field positions
  localparam int HDR_W          = 128;
  localparam int HDR_ATTR_LSB   = 0;
  localparam int HDR_CMD_LO_LSB = 36;
  localparam int HDR_CMD_HI_LSB = 40;
  localparam int HDR_ADDR_LO_LSB = 64;
  localparam int HDR_ADDR_HI_LSB = 96;
  localparam logic [127:0] HDR_RESET = 128'h0;

  // Virtual channel capability header
  localparam logic [15:0] VC_CAP_ID      = 16'h0002;
  localparam logic [3:0]  VC_CAP_VERSION = 4'h1;
  localparam logic [11:0] VC_NEXT_PTR    = 12'h000;

  // Channel 0 resource control
  localparam int          TC_MAP_LSB     = 1;
  localparam logic [6:0]  TC_MAP_RESET   = 7'h7F;
  localparam int          VC_ENABLE_BIT  = 31;

  // Auxiliary I/O field positions
  localparam int          AUX_DATA_CLR_LSB = 0;
  localparam int          AUX_DATA_SET_LSB = 4;
  localparam int          AUX_EN_CLR_LSB   = 8;
  localparam int          AUX_EN_SET_LSB   = 12;
  localparam int          AUX_IN_LSB       = 16;
  localparam logic [3:0]  AUX_DATA_RESET   = 4'h0;
  localparam logic [3:0]  AUX_EN_RESET     = 4'h0;

  // Replay and acknowledge latency timers
  localparam int          REPLAY_W         = 12;
  localparam int          REPLAY_LSB       = 0;
  localparam int          REPLAY_EN_BIT    = 12;
  localparam int          ACK_LAT_W        = 14;
  localparam int          ACK_LAT_LSB      = 16;
  localparam int          ACK_LAT_EN_BIT   = 30;
  localparam logic [11:0] REPLAY_RESET     = 12'h000;
  localparam logic [13:0] ACK_LAT_RESET    = 14'h0000;

  typedef enum logic [0:0] {
    ECR_BUS_IDLE = 1'b0,
    ECR_BUS_ACK  = 1'b1
  } ecr_bus_state_t;

endpackage : ecr_pkg

// ### src/ecr_regs.sv
// Extended configuration register bank: secondary error log, virtual
// channel capability, auxiliary I/O and link timer settings.
// Assumes an Avalon-MM master on the same clock and error logic that
// pulses log_valid for one cycle with the captured transaction fields.
`timescale 1ns/100ps
`default_nettype none
module ecr_regs
  import ecr_pkg::*;
#(
  parameter int AUX_COUNT = 4
) (
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  // Avalon-MM slave
  input  wire logic [ecr_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [ecr_pkg::DATA_W-1:0]    avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output var  logic [ecr_pkg::DATA_W-1:0]    avs_readdata,
  output var  logic                          avs_waitrequest,
  // Secondary error capture
  input  wire logic                          log_valid,
  input  wire logic [ecr_pkg::PTR_W-1:0]     log_pointer,
  input  wire logic                          log_dual_addr,
  input  wire logic [3:0]                    log_attr_cbe,
  input  wire logic [31:0]                   log_attr_ad,
  input  wire logic [3:0]                    log_cmd_lo,
  input  wire logic [3:0]                    log_cmd_hi,
  input  wire logic [31:0]                   log_addr_lo,
  input  wire logic [31:0]                   log_addr_hi,
  // Auxiliary pins
  input  wire logic [AUX_COUNT-1:0]          aux_input,
  output var  logic [AUX_COUNT-1:0]          aux_output,
  output var  logic [AUX_COUNT-1:0]          aux_output_oe,
  // Settings to the link layer
  output var  logic [ecr_pkg::REPLAY_W-1:0]  replay_timer,
  output var  logic                          replay_timer_en,
  output var  logic [ecr_pkg::ACK_LAT_W-1:0] ack_latency_timer,
  output var  logic [6:0]                    tc_map_upper
);

  import ecr_pkg::*;

  // Bus state
  ecr_bus_state_t state_reg;
  ecr_bus_state_t state_next;
  logic [31:0]    readdata_next;
  logic           waitrequest_next;

  // Storage
  logic [PTR_W-1:0]     err_ptr_reg;
  logic [PTR_W-1:0]     err_ptr_next;
  logic [HDR_W-1:0]     header_reg;
  logic [HDR_W-1:0]     header_next;
  logic [6:0]           tc_map_reg;
  logic [6:0]           tc_map_next;
  logic [AUX_COUNT-1:0] aux_data_reg;
  logic [AUX_COUNT-1:0] aux_data_next;
  logic [AUX_COUNT-1:0] aux_en_reg;
  logic [AUX_COUNT-1:0] aux_en_next;
  logic [REPLAY_W-1:0]  replay_reg;
  logic [REPLAY_W-1:0]  replay_next;
  logic                 replay_en_reg;
  logic                 replay_en_next;
  logic [ACK_LAT_W-1:0] ack_lat_reg;
  logic [ACK_LAT_W-1:0] ack_lat_next;
  logic [AUX_COUNT-1:0] aux_in_sync;

  ecr_sync #(
    .WIDTH    (AUX_COUNT)
  ) u_aux_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in (aux_input),
    .sync_out (aux_in_sync)
  );

  // Address decode
  wire logic [11:0] word_addr = {avs_address[11:2], 2'b00};
  wire logic sel_ptr   = (word_addr == OFS_SEC_ERR_PTR);
  wire logic sel_hdr0  = (word_addr == OFS_SEC_HDR_0);
  wire logic sel_hdr1  = (word_addr == OFS_SEC_HDR_1);
  wire logic sel_hdr2  = (word_addr == OFS_SEC_HDR_2);
  wire logic sel_hdr3  = (word_addr == OFS_SEC_HDR_3);
  wire logic sel_vchdr = (word_addr == OFS_VC_CAP_HDR);
  wire logic sel_rctl  = (word_addr == OFS_VC0_RES_CTRL);
  wire logic sel_aux   = (word_addr == OFS_AUX_IO);
  wire logic sel_tmr   = (word_addr == OFS_TIMERS);

  // Commit happens only at the edge where waitrequest is seen low
  wire logic bus_req   = avs_read | avs_write;
  wire logic wr_commit = avs_write & ~avs_waitrequest;

  // Byte-lane masked write data
  wire logic [31:0] be_mask = {{8{avs_byteenable[3]}},
                               {8{avs_byteenable[2]}},
                               {8{avs_byteenable[1]}},
                               {8{avs_byteenable[0]}}};
  wire logic [31:0] wdata_m = avs_writedata & be_mask;

  // Composed read views
  wire logic [31:0] ptr_view =
    {{(32-PTR_W){1'b0}}, err_ptr_reg};
  wire logic [31:0] vchdr_view =
    {VC_NEXT_PTR, VC_CAP_VERSION, VC_CAP_ID};
  wire logic [31:0] rctl_view =
    {1'b1, 23'h000000, tc_map_reg, 1'b1};
  wire logic [31:0] aux_view =
    {12'h000, aux_in_sync, aux_en_reg, aux_en_reg,
     aux_data_reg, aux_data_reg};
  wire logic [31:0] tmr_view =
    {1'b0, 1'b0, ack_lat_reg, 3'b000,
     replay_en_reg, replay_reg};

  // Reserved words and the fixed-zero channel registers fall to zero
  wire logic [31:0] read_mux =
    sel_ptr   ? ptr_view           :
    sel_hdr0  ? header_reg[31:0]   :
    sel_hdr1  ? header_reg[63:32]  :
    sel_hdr2  ? header_reg[95:64]  :
    sel_hdr3  ? header_reg[127:96] :
    sel_vchdr ? vchdr_view         :
    sel_rctl  ? rctl_view          :
    sel_aux   ? aux_view           :
    sel_tmr   ? tmr_view           :
    32'h00000000;

  // Header image built from one capture
  wire logic [HDR_W-1:0] captured_header = {
    log_dual_addr ? log_addr_hi : 32'h00000000,
    log_addr_lo,
    20'h00000,
    log_dual_addr ? log_cmd_hi : 4'h0,
    log_cmd_lo,
    log_attr_cbe,
    log_attr_ad
  };

  // Auxiliary write strobes, lane masked
  wire logic aux_wr = wr_commit & sel_aux;
  wire logic [3:0] data_clr =
    aux_wr ? wdata_m[AUX_DATA_CLR_LSB +: 4] : 4'h0;
  wire logic [3:0] data_set =
    aux_wr ? wdata_m[AUX_DATA_SET_LSB +: 4] : 4'h0;
  wire logic [3:0] en_clr =
    aux_wr ? wdata_m[AUX_EN_CLR_LSB +: 4] : 4'h0;
  wire logic [3:0] en_set =
    aux_wr ? wdata_m[AUX_EN_SET_LSB +: 4] : 4'h0;

  // Bus handshake: one wait cycle, then a single-cycle answer
  always_comb
  begin
    state_next       = state_reg;
    waitrequest_next = 1'b1;
    readdata_next    = avs_readdata;
    case (state_reg)
      ECR_BUS_IDLE:
      begin
        if (bus_req)
        begin
          state_next       = ECR_BUS_ACK;
          waitrequest_next = 1'b0;
          readdata_next    = avs_read ? read_mux : 32'h00000000;
        end
      end
      ECR_BUS_ACK:
      begin
        // Back to idle so a held request is not answered twice
        state_next       = ECR_BUS_IDLE;
        waitrequest_next = 1'b1;
      end
      default:
      begin
        state_next       = ECR_BUS_IDLE;
        waitrequest_next = 1'b1;
      end
    endcase
  end

  // Error log: a new capture overwrites the old one
  always_comb
  begin
    err_ptr_next = err_ptr_reg;
    header_next  = header_reg;
    if (log_valid)
    begin
      err_ptr_next = log_pointer;
      header_next  = captured_header;
    end
  end

  // Channel 0 map, only the upper seven classes are writable
  always_comb
  begin
    tc_map_next = tc_map_reg;
    if (wr_commit && sel_rctl && avs_byteenable[0])
    begin
      tc_map_next = avs_writedata[TC_MAP_LSB +: 7];
    end
  end

  // Set is applied after clear, so a word with both wins for set
  always_comb
  begin
    aux_data_next = (aux_data_reg & ~data_clr) | data_set;
    aux_en_next   = (aux_en_reg & ~en_clr) | en_set;
  end

  // Timer settings with byte-lane control
  always_comb
  begin
    replay_next    = replay_reg;
    replay_en_next = replay_en_reg;
    ack_lat_next   = ack_lat_reg;
    if (wr_commit && sel_tmr)
    begin
      if (avs_byteenable[0])
      begin
        replay_next[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1])
      begin
        replay_next[11:8] = avs_writedata[11:8];
        replay_en_next    = avs_writedata[REPLAY_EN_BIT];
      end
      if (avs_byteenable[2])
      begin
        ack_lat_next[7:0] = avs_writedata[23:16];
      end
      if (avs_byteenable[3])
      begin
        ack_lat_next[13:8] = avs_writedata[29:24];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg       <= ECR_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end
    else
    begin
      state_reg       <= state_next;
      avs_waitrequest <= waitrequest_next;
      avs_readdata    <= readdata_next;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      err_ptr_reg <= PTR_RESET;
      header_reg  <= HDR_RESET;
    end
    else
    begin
      err_ptr_reg <= err_ptr_next;
      header_reg  <= header_next;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tc_map_reg   <= TC_MAP_RESET;
      aux_data_reg <= AUX_DATA_RESET;
      aux_en_reg   <= AUX_EN_RESET;
    end
    else
    begin
      tc_map_reg   <= tc_map_next;
      aux_data_reg <= aux_data_next;
      aux_en_reg   <= aux_en_next;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      replay_reg    <= REPLAY_RESET;
      replay_en_reg <= 1'b0;
      ack_lat_reg   <= ACK_LAT_RESET;
    end
    else
    begin
      replay_reg    <= replay_next;
      replay_en_reg <= replay_en_next;
      ack_lat_reg   <= ack_lat_next;
    end
  end

  // Pin drivers as separate flops so the outputs come straight from them
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aux_output    <= '0;
      aux_output_oe <= '0;
    end
    else
    begin
      aux_output    <= aux_data_next & aux_en_next;
      aux_output_oe <= aux_en_next;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      replay_timer      <= REPLAY_RESET;
      replay_timer_en   <= 1'b0;
      ack_latency_timer <= ACK_LAT_RESET;
      tc_map_upper      <= TC_MAP_RESET;
    end
    else
    begin
      replay_timer      <= replay_next;
      replay_timer_en   <= replay_en_next;
      ack_latency_timer <= ack_lat_next;
      tc_map_upper      <= tc_map_next;
    end
  end

endmodule : ecr_regs
`default_nettype wire

// ### src/ecr_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs change slowly compared with the clock.
`timescale 1ns/100ps
`default_nettype none
module ecr_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : ecr_sync
`default_nettype wire

// ### testbench/ecr_regs_chk.sv
// Concurrent checks on the register bank ports.
// Assumes it is bound to ecr_regs with the default AUX_COUNT of 4.
`timescale 1ns/100ps
`default_nettype none
module ecr_regs_chk
  import ecr_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [3:0]  aux_output,
  input wire logic [3:0]  aux_output_oe,
  input wire logic [11:0] replay_timer
);
  wire logic       rd_ans = avs_read && !avs_waitrequest;
  wire logic       wr_ans = avs_write && !avs_waitrequest;
  wire logic [9:0] word   = avs_address[11:2];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  oe_gate_a: assert property ((aux_output & ~aux_output_oe) == 4'h0)
    else $error("aux pin driven while disabled");
  vc_header_a: assert property (rd_ans && word == OFS_VC_CAP_HDR[11:2]
    |-> avs_readdata == {VC_NEXT_PTR, VC_CAP_VERSION, VC_CAP_ID})
    else $error("bad capability header");
  ptr_upper_a: assert property (rd_ans && word == OFS_SEC_ERR_PTR[11:2]
    |-> avs_readdata[31:5] == 27'h0) else $error("pointer upper bits set");
  hdr_resv_a: assert property (rd_ans && word == OFS_SEC_HDR_1[11:2]
    |-> avs_readdata[31:12] == 20'h0) else $error("header reserved set");
  tc_fixed_a: assert property (rd_ans && word == OFS_VC0_RES_CTRL[11:2]
    |-> avs_readdata[0] && avs_readdata[31] && avs_readdata[30:8] == 23'h0)
    else $error("bad channel control fixed bits");
  ack_en_a: assert property (rd_ans && word == OFS_TIMERS[11:2]
    |-> avs_readdata[31:30] == 2'h0 && avs_readdata[15:13] == 3'h0)
    else $error("timer read-only bits set");
  replay_copy_a: assert property (wr_ans && word == OFS_TIMERS[11:2]
    && avs_byteenable[1:0] == 2'h3
    |=> replay_timer == $past(avs_writedata[11:0]))
    else $error("replay timer not written");
  aux_clr_a: assert property (wr_ans && word == OFS_AUX_IO[11:2]
    && avs_byteenable[0] |=> (aux_output
    & $past(avs_writedata[3:0] & ~avs_writedata[7:4])) == 4'h0)
    else $error("aux data not cleared");
  aux_en_set_a: assert property (wr_ans && word == OFS_AUX_IO[11:2]
    && avs_byteenable[1] |=> (aux_output_oe & $past(avs_writedata[15:12]))
    == $past(avs_writedata[15:12])) else $error("aux enable not set");

  cover property (rd_ans && word == OFS_SEC_HDR_3[11:2]);
  cover property (wr_ans && word == OFS_AUX_IO[11:2]);
  cover property (wr_ans && word == OFS_TIMERS[11:2]);
endmodule : ecr_regs_chk

bind ecr_regs ecr_regs_chk u_chk (.clock(clock), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .aux_output(aux_output), .aux_output_oe(aux_output_oe),
  .replay_timer(replay_timer));
`default_nettype wire

// ### testbench/ecr_regs_tb.sv
// Self-checking bench for the extended configuration register bank.
// Assumes ecr_regs with its bound checker; the bench drives every port.
`timescale 1ns/100ps
`default_nettype none
module ecr_regs_tb;
  import ecr_pkg::*;
  logic        clock = 1'b0, rst_b = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
  logic [3:0]  avs_byteenable = 4'h0;
  logic        avs_waitrequest, replay_timer_en;
  logic        log_valid = 1'b0, log_dual_addr = 1'b0;
  logic [4:0]  log_pointer = 5'h00;
  logic [3:0]  log_attr_cbe = 4'h0, log_cmd_lo = 4'h0, log_cmd_hi = 4'h0;
  logic [31:0] log_attr_ad = 32'h0, log_addr_lo = 32'h0, log_addr_hi = 32'h0;
  logic [3:0]  aux_input = 4'h0, aux_output, aux_output_oe;
  logic [11:0] replay_timer;
  logic [13:0] ack_latency_timer;
  logic [6:0]  tc_map_upper;
  int          fails = 0, tests_run = 0, cyc = 0;
  // RO and unmapped words first, the three writable words last
  localparam logic [11:0] ADR [0:18] = '{12'h138, 12'h13C, 12'h140,
    12'h144, 12'h148, 12'h14C, 12'h150, 12'h154, 12'h158, 12'h15C, 12'h160,
    12'h168, 12'h200, 12'h308, 12'h314, 12'hFFC, 12'h164, 12'h304, 12'h310};

  always #50 clock = ~clock;

  ecr_regs dut (.clock(clock), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .log_valid(log_valid), .log_pointer(log_pointer),
    .log_dual_addr(log_dual_addr), .log_attr_cbe(log_attr_cbe),
    .log_attr_ad(log_attr_ad), .log_cmd_lo(log_cmd_lo),
    .log_cmd_hi(log_cmd_hi), .log_addr_lo(log_addr_lo),
    .log_addr_hi(log_addr_hi), .aux_input(aux_input),
    .aux_output(aux_output), .aux_output_oe(aux_output_oe),
    .replay_timer(replay_timer), .replay_timer_en(replay_timer_en),
    .ack_latency_timer(ack_latency_timer), .tc_map_upper(tc_map_upper));

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Request held until waitrequest is sampled low, released at that edge
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(rdat, exp);
  endtask : rd_chk

  function automatic logic [31:0] rst_exp(input logic [11:0] a);
    if (a == OFS_VC_CAP_HDR)
      return {VC_NEXT_PTR, VC_CAP_VERSION, VC_CAP_ID};
    return (a == OFS_VC0_RES_CTRL) ? 32'h800000FF : 32'h0;
  endfunction : rst_exp

  task automatic do_log(input logic dual);
    @(posedge clock);
    log_valid <= 1'b1;
    log_dual_addr <= dual;
    log_pointer <= {4'h9, dual};
    log_attr_cbe <= {3'h5, dual};
    log_attr_ad <= 32'h11223344;
    log_cmd_lo <= 4'h6;
    log_cmd_hi <= 4'hC;
    log_addr_lo <= 32'h55667788;
    log_addr_hi <= 32'h99AABBCC;
    @(posedge clock);
    log_valid <= 1'b0;
    rd_chk(OFS_SEC_ERR_PTR, {27'h0, 4'h9, dual});
    rd_chk(OFS_SEC_HDR_0, 32'h11223344);
    rd_chk(OFS_SEC_HDR_1, {20'h0, dual ? 4'hC : 4'h0, 4'h6, 3'h5, dual});
    chk({28'h0, rdat[11:8]}, dual ? 32'hC : 32'h0);
    rd_chk(OFS_SEC_HDR_2, 32'h55667788);
    rd_chk(OFS_SEC_HDR_3, dual ? 32'h99AABBCC : 32'h0);
  endtask : do_log

  // Hang guard well above the few hundred cycles the run needs
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      fails++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    chk({2'h0, aux_output_oe, aux_output, replay_timer_en,
         ack_latency_timer, tc_map_upper}, 32'h7F);
    chk({20'h0, replay_timer}, 32'h0);
    for (int i = 0; i < 19; i++)
      rd_chk(ADR[i], rst_exp(ADR[i]));
    for (int i = 0; i < 16; i++)
      bus(1'b1, ADR[i], 32'hFFFFFFFF, 4'hF);
    for (int i = 0; i < 16; i++)
      rd_chk(ADR[i], rst_exp(ADR[i]));
    bus(1'b1, OFS_VC0_RES_CTRL, 32'h0, 4'hF);
    rd_chk(OFS_VC0_RES_CTRL, 32'h80000001);
    bus(1'b1, OFS_VC0_RES_CTRL, 32'hFFFF00AA, 4'hF);
    rd_chk(OFS_VC0_RES_CTRL, 32'h800000AB);
    bus(1'b1, OFS_VC0_RES_CTRL, 32'hFF, 4'hE);
    rd_chk(OFS_VC0_RES_CTRL, 32'h800000AB);
    chk({25'h0, tc_map_upper}, 32'h55);
    bus(1'b1, OFS_TIMERS, 32'hFFFFFFFF, 4'hF);
    rd_chk(OFS_TIMERS, 32'h3FFF1FFF);
    chk({replay_timer_en, ack_latency_timer, 5'h0, replay_timer},
        32'hFFFE0FFF);
    bus(1'b1, OFS_TIMERS, 32'h12345678, 4'hF);
    rd_chk(OFS_TIMERS, 32'h12341678);
    bus(1'b1, OFS_TIMERS, 32'h0, 4'h3);
    rd_chk(OFS_TIMERS, 32'h12340000);
    aux_input <= 4'h9;
    bus(1'b1, OFS_AUX_IO, 32'hF0F0, 4'hF);
    @(negedge clock);
    chk({24'h0, aux_output_oe, aux_output}, 32'hFF);
    rd_chk(OFS_AUX_IO, 32'h0009FFFF);
    bus(1'b1, OFS_AUX_IO, 32'h5, 4'hF);
    rd_chk(OFS_AUX_IO, 32'h0009FFAA);
    bus(1'b1, OFS_AUX_IO, 32'h300, 4'hF);
    @(negedge clock);
    chk({24'h0, aux_output_oe, aux_output}, 32'hC8);
    bus(1'b1, OFS_AUX_IO, 32'h11, 4'hF);
    rd_chk(OFS_AUX_IO, 32'h0009CCBB);
    bus(1'b1, OFS_AUX_IO, 32'hFFF0, 4'hC);
    rd_chk(OFS_AUX_IO, 32'h0009CCBB);
    do_log(1'b1);
    do_log(1'b0);
    print_verdict();
  end
endmodule : ecr_regs_tb
`default_nettype wire
